// file: rtl/ars_pkg.sv
package ars_pkg;

    // =========================================================
    // register map
    localparam logic [5:0]  ADDR_STATUS    = 6'h00;
    localparam logic [5:0]  ADDR_MODE      = 6'h01;
    localparam logic [5:0]  ADDR_IFMODE    = 6'h02;
    localparam logic [5:0]  ADDR_CHECKSUM  = 6'h03;
    localparam logic [5:0]  ADDR_RESULT    = 6'h04;
    localparam logic [5:0]  ADDR_AUXCFG    = 6'h06;

    // =========================================================
    // reset values and writable masks
    localparam logic [15:0] MODE_RESET     = 16'h0000;
    localparam logic [15:0] IFMODE_RESET   = 16'h0000;
    localparam logic [15:0] AUXCFG_RESET   = 16'h0800;
    localparam logic [15:0] AUXCFG_MASK    = 16'h1FFF;
    localparam logic [23:0] CHECKSUM_RESET = 24'h000000;
    localparam logic [23:0] RESULT_RESET   = 24'h000000;
    localparam logic [7:0]  STATUS_RESET   = 8'h80;

    // =========================================================
    // field positions
    localparam int IF_SHORT_WORD_BIT    = 0;
    localparam int IF_INTEGRITY_BIT     = 5;
    localparam int IF_STATUS_APPEND_BIT = 6;
    localparam int IF_ALTERNATE_SYNC_MODE_BIT      = 12;
    localparam int AUX_MUX_BIT          = 12;
    localparam int AUX_SYNC_EN_BIT      = 11;
    localparam int MODE_DELAY_LSB       = 8;
    localparam int MODE_DELAY_MSB       = 10;
    localparam int STAT_READY_N_BIT     = 7;
    localparam int STAT_INTEG_ERR_BIT   = 4;

    // =========================================================
    // transfer lengths in bits, data left aligned in a 32-bit word
    localparam logic [5:0]  LEN_8          = 6'h08;
    localparam logic [5:0]  LEN_16         = 6'h10;
    localparam logic [5:0]  LEN_24         = 6'h18;
    localparam logic [5:0]  LEN_32         = 6'h20;

    // =========================================================
    // timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int DELAY_STEP_NS   = 1000;
    localparam int DELAY_STEP_CYC  = (DELAY_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SETTLE_W        = 9;

    // =========================================================
    // channel sequencer states
    typedef enum logic [3:0]
    {
        ARS_SEQ_CONVERT   = 4'b0001,
        ARS_SEQ_SETTLE    = 4'b0010,
        ARS_SEQ_WAIT_SYNC = 4'b0100,
        ARS_SEQ_HOLD      = 4'b1000
    } ars_seq_e;

endpackage : ars_pkg

// file: rtl/ars_checksum.sv
`timescale 1ns/1ps

module ars_checksum (
    input  wire logic [15:0] mode_in,
    input  wire logic [15:0] auxcfg_in,
    input  wire logic [23:0] other_regs_xor_in,
    input  wire logic        enable_in,
    output logic      [23:0] sum_out,
    output logic      [23:0] check_out
);

    // =========================================================
    // xor of covered registers
    // interface mode, result and status never enter this sum
    always_comb
    begin
        sum_out = other_regs_xor_in ^ {8'h00, mode_in} ^ {8'h00, auxcfg_in}; // [R3] [R18] [R19]
    end

    always_comb
    begin
        check_out = enable_in ? sum_out : ars_pkg::CHECKSUM_RESET; // [R4]
    end

endmodule : ars_checksum

// file: rtl/ars_regs.sv
`timescale 1ns/1ps

// Functional notes
// [R1] result is 24 bits with short word select clear, 16 bits when set
// [R2] word length change never resets conversion; next new result takes new length
// [R3] read-only checksum at 0x03, 24-bit xor of user registers
// [R4] checksum reads zero unless integrity enable is set
// [R5] result at 0x04 is offset binary, or straight binary for unipolar channels
// [R6] result read drives ready status bit and ready output high
// [R7] result may be reread unchanged; ready output then says nothing new
// [R8] after a result read command, no new result is written until access ends
// [R9] status append adds status byte after result, 32 bits at default length
// [R10] external mux control drives both aux pins with the channel code
// [R11] per-channel pin selection kept; at most four channels sequenced
// [R12] programmable settling delay after each external mux switch
// [R13] sync enable set: low sync holds modulator and filter in reset
// [R14] alternate sync: low sync at channel switch withholds next conversion
// [R15] alternate sync: rising sync releases the withheld conversion
// [R16] host selects alternate sync only with several channels enabled
// [R17] integrity enabled: any covered change sets error flag; disable clears it
// [R18] checksum excludes interface mode, result and status registers
// [R19] checksum follows register contents within a clock of any write
module ars_regs (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic        reg_done_in,
    input  wire logic [23:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    output logic      [5:0]  reg_rlen_out,
    input  wire logic        conv_valid_in,
    input  wire logic [23:0] conv_sample_in,
    input  wire logic [3:0]  chan_enable_in,
    input  wire logic [3:0]  polarity_select_in,
    input  wire logic [23:0] other_regs_xor_in,
    input  wire logic        sync_in,
    output logic             ready_n_out,
    output logic             filter_reset_out,
    output logic             conv_run_out,
    output logic      [1:0]  channel_out,
    output logic             aux_pin_zero_out,
    output logic             aux_pin_zero_oe_n_out,
    output logic             aux_pin_one_out,
    output logic             aux_pin_one_oe_n_out
);

    // =========================================================
    // decode helpers
    function automatic logic addr_is(input logic [5:0] a, input logic [5:0] target);
        addr_is = (a == target);
    endfunction : addr_is

    // next enabled channel after cur, wrapping; only four slots exist
    function automatic logic [1:0] next_channel(input logic [3:0] mask, input logic [1:0] cur);
        logic [1:0] pick;
        logic       found;
        logic [1:0] cand;
        pick  = cur;
        found = 1'b0;
        cand  = cur;
        for (int i = 1; i <= 4; i++)
        begin
            cand = 2'(cur + 2'(i));
            if (!found && mask[cand])
            begin
                pick  = cand;
                found = 1'b1;
            end
        end
        next_channel = pick;
    endfunction : next_channel

    // =========================================================
    // state
    logic [15:0]        mode_reg, ifmode_reg, auxcfg_reg;
    logic [23:0]        result_reg, result_next, snap_reg, sum_now, check_now, coded;
    logic [1:0]         res_chan_reg, res_chan_next, chan_reg, chan_after;
    logic               ready_n_reg, block_reg, integ_en_q_reg, integ_err_reg;
    logic [31:0]        rdata_reg, res_word;
    logic [5:0]         rlen_reg, res_len;
    logic [ars_pkg::SETTLE_W-1:0] settle_reg, settle_load;
    ars_pkg::ars_seq_e  state_reg, state_next;
    logic               short_word, integ_en, status_append, alternate_sync_mode, mux_ctrl, sync_en;
    logic               rd_result, accept, sync_reset;
    logic [15:0]        rounded;
    logic [7:0]         status_byte;

    assign short_word    = ifmode_reg[ars_pkg::IF_SHORT_WORD_BIT];
    assign integ_en      = ifmode_reg[ars_pkg::IF_INTEGRITY_BIT];
    assign status_append = ifmode_reg[ars_pkg::IF_STATUS_APPEND_BIT];
    assign alternate_sync_mode      = ifmode_reg[ars_pkg::IF_ALTERNATE_SYNC_MODE_BIT];
    assign mux_ctrl      = auxcfg_reg[ars_pkg::AUX_MUX_BIT];
    assign sync_en       = auxcfg_reg[ars_pkg::AUX_SYNC_EN_BIT];
    assign rd_result     = reg_rd_in && addr_is(reg_addr_in, ars_pkg::ADDR_RESULT);

    // =========================================================
    // checksum
    ars_checksum u_checksum (
        .mode_in           (mode_reg),
        .auxcfg_in         (auxcfg_reg),
        .other_regs_xor_in (other_regs_xor_in),
        .enable_in         (integ_en),
        .sum_out           (sum_now),
        .check_out         (check_now)
    );

    // =========================================================
    // register writes; read-only and unmapped addresses ignore writes
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mode_reg   <= ars_pkg::MODE_RESET;
            ifmode_reg <= ars_pkg::IFMODE_RESET;
            auxcfg_reg <= ars_pkg::AUXCFG_RESET; // [R13]
        end
        else if (reg_wr_in)
        begin
            if (addr_is(reg_addr_in, ars_pkg::ADDR_MODE))
            begin
                mode_reg <= reg_wdata_in[15:0];
            end
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_IFMODE))
            begin
                // word length write touches nothing else in the converter
                ifmode_reg <= reg_wdata_in[15:0]; // [R2]
            end
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_AUXCFG))
            begin
                auxcfg_reg <= reg_wdata_in[15:0] & ars_pkg::AUXCFG_MASK;
            end
        end
    end

    // =========================================================
    // integrity monitor: snapshot taken on the enable edge
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            integ_en_q_reg <= 1'b0;
            snap_reg       <= ars_pkg::CHECKSUM_RESET;
            integ_err_reg  <= 1'b0;
        end
        else
        begin
            integ_en_q_reg <= integ_en;
            if (integ_en && !integ_en_q_reg)
            begin
                snap_reg <= sum_now;
            end
            if (!integ_en)
            begin
                integ_err_reg <= 1'b0; // [R17]
            end
            else if (integ_en_q_reg && (sum_now != snap_reg))
            begin
                integ_err_reg <= 1'b1; // [R17]
            end
        end
    end

    // =========================================================
    // result coding; unipolar clamps negative codes to zero
    assign coded = polarity_select_in[chan_reg] ? (conv_sample_in[23] ? 24'h000000 : {conv_sample_in[22:0], 1'b0})
                                                : {~conv_sample_in[23], conv_sample_in[22:0]}; // [R5]
    // round to 16 bits, saturating at the top code
    assign rounded = (coded[23:8] == 16'hFFFF) ? 16'hFFFF : 16'(coded[23:8] + {15'h0000, coded[7]});
    // a result arriving with the read command is stored first
    assign accept        = conv_valid_in && !block_reg; // [R8]
    assign result_next   = accept ? (short_word ? {rounded, 8'h00} : coded) : result_reg; // [R1] [R2]
    assign res_chan_next = accept ? chan_reg : res_chan_reg;

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            result_reg   <= ars_pkg::RESULT_RESET;
            res_chan_reg <= 2'h0;
        end
        else
        begin
            result_reg   <= result_next; // [R7]
            res_chan_reg <= res_chan_next;
        end
    end

    // =========================================================
    // ready flag and access blocking
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            ready_n_reg <= 1'b1;
        else if (rd_result)
            ready_n_reg <= 1'b1; // [R6] [R7]
        else if (accept)
            ready_n_reg <= 1'b0;
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            block_reg <= 1'b0;
        else if (rd_result)
            block_reg <= 1'b1; // [R8]
        else if (reg_done_in)
            block_reg <= 1'b0;
    end

    // =========================================================
    // read port
    always_comb
    begin
        status_byte = {6'h00, res_chan_next};
        status_byte[ars_pkg::STAT_READY_N_BIT]   = accept ? 1'b0 : ready_n_reg;
        status_byte[ars_pkg::STAT_INTEG_ERR_BIT] = integ_err_reg;
    end
    // an old result is cut, not rounded, when length changed since
    assign res_word = short_word ? {result_next[23:8], (status_append ? status_byte : 8'h00), 8'h00}
                                 : {result_next, (status_append ? status_byte : 8'h00)}; // [R1] [R9]
    assign res_len  = short_word ? (status_append ? ars_pkg::LEN_24 : ars_pkg::LEN_16)
                                 : (status_append ? ars_pkg::LEN_32 : ars_pkg::LEN_24); // [R9]
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rdata_reg <= 32'h00000000;
            rlen_reg  <= ars_pkg::LEN_8;
        end
        else if (reg_rd_in)
        begin
            if (addr_is(reg_addr_in, ars_pkg::ADDR_STATUS))
                {rdata_reg, rlen_reg} <= {status_byte, 24'h000000, ars_pkg::LEN_8};
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_MODE))
                {rdata_reg, rlen_reg} <= {mode_reg, 16'h0000, ars_pkg::LEN_16};
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_IFMODE))
                {rdata_reg, rlen_reg} <= {ifmode_reg, 16'h0000, ars_pkg::LEN_16};
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_CHECKSUM))
                {rdata_reg, rlen_reg} <= {check_now, 8'h00, ars_pkg::LEN_24}; // [R3] [R4] [R19]
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_RESULT))
                {rdata_reg, rlen_reg} <= {res_word, res_len}; // [R1] [R9]
            else if (addr_is(reg_addr_in, ars_pkg::ADDR_AUXCFG))
                {rdata_reg, rlen_reg} <= {auxcfg_reg, 16'h0000, ars_pkg::LEN_16};
            else
                {rdata_reg, rlen_reg} <= {32'h00000000, ars_pkg::LEN_8};
        end
    end

    // =========================================================
    // channel sequencer
    // alternate sync only bites at a switch, so a single channel never waits
    assign sync_reset  = sync_en && !alternate_sync_mode && !sync_in; // [R13] [R16]
    assign chan_after  = next_channel(chan_enable_in, chan_reg); // [R11]
    assign settle_load = mux_ctrl ? ars_pkg::SETTLE_W'(int'(mode_reg[ars_pkg::MODE_DELAY_MSB:ars_pkg::MODE_DELAY_LSB])
                                    * ars_pkg::DELAY_STEP_CYC)
                                  : '0; // [R12]

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ars_pkg::ARS_SEQ_HOLD:
            begin
                if (!sync_reset)
                begin
                    state_next = ars_pkg::ARS_SEQ_SETTLE; // [R13]
                end
            end
            ars_pkg::ARS_SEQ_CONVERT:
            begin
                if (conv_valid_in && (chan_after != chan_reg))
                begin
                    if (sync_en && alternate_sync_mode && !sync_in)
                    begin
                        state_next = ars_pkg::ARS_SEQ_WAIT_SYNC; // [R14]
                    end
                    else
                    begin
                        state_next = ars_pkg::ARS_SEQ_SETTLE;
                    end
                end
            end
            ars_pkg::ARS_SEQ_WAIT_SYNC:
            begin
                if (sync_in)
                begin
                    state_next = ars_pkg::ARS_SEQ_SETTLE; // [R15]
                end
            end
            ars_pkg::ARS_SEQ_SETTLE:
            begin
                if (settle_reg == '0)
                begin
                    state_next = ars_pkg::ARS_SEQ_CONVERT; // [R12]
                end
            end
            default:
            begin
                state_next = ars_pkg::ARS_SEQ_HOLD;
            end
        endcase
        if (sync_reset)
        begin
            state_next = ars_pkg::ARS_SEQ_HOLD; // [R13]
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_reg <= ars_pkg::ARS_SEQ_HOLD;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            chan_reg <= 2'h0;
        end
        else if (sync_reset)
        begin
            chan_reg <= next_channel(chan_enable_in, 2'h3);
        end
        else if ((state_reg == ars_pkg::ARS_SEQ_CONVERT) && conv_valid_in)
        begin
            chan_reg <= chan_after; // [R11]
        end
    end

    // settle counter loads on every entry into the settle state
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            settle_reg <= '0;
        end
        else if ((state_next == ars_pkg::ARS_SEQ_SETTLE) && (state_reg != ars_pkg::ARS_SEQ_SETTLE))
        begin
            settle_reg <= settle_load; // [R12]
        end
        else if ((state_reg == ars_pkg::ARS_SEQ_SETTLE) && (settle_reg != '0))
        begin
            settle_reg <= ars_pkg::SETTLE_W'(settle_reg - 1'b1);
        end
    end

    // =========================================================
    // outputs
    assign reg_rdata_out         = rdata_reg;
    assign reg_rlen_out          = rlen_reg;
    assign ready_n_out           = ready_n_reg; // [R6]
    assign filter_reset_out      = (state_reg == ars_pkg::ARS_SEQ_HOLD); // [R13]
    assign conv_run_out          = (state_reg == ars_pkg::ARS_SEQ_CONVERT) && (chan_enable_in != 4'h0);
    assign channel_out           = chan_reg;
    // pins are released unless the mux code is being driven
    assign aux_pin_zero_out      = mux_ctrl & chan_reg[0]; // [R10]
    assign aux_pin_one_out       = mux_ctrl & chan_reg[1]; // [R10]
    assign aux_pin_zero_oe_n_out = ~mux_ctrl;
    assign aux_pin_one_oe_n_out  = ~mux_ctrl;

endmodule : ars_regs

// file: tb/ars_regs_props.sv
`timescale 1ns/1ps
// ==========
// port checker
module ars_props (
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic        reg_done_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [5:0]  reg_rlen_out,
    input wire logic        conv_valid_in,
    input wire logic        ready_n_out,
    input wire logic        filter_reset_out,
    input wire logic        conv_run_out,
    input wire logic [1:0]  channel_out,
    input wire logic        aux_pin_zero_out,
    input wire logic        aux_pin_zero_oe_n_out,
    input wire logic        aux_pin_one_out,
    input wire logic        aux_pin_one_oe_n_out
);
    logic rd_res;
    logic blocked_reg;
    assign rd_res = reg_rd_in && (reg_addr_in == ars_pkg::ADDR_RESULT);
    // blocking lasts through the cycle of the end pulse
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            blocked_reg <= 1'b0;
        else if (rd_res)
            blocked_reg <= 1'b1;
        else if (reg_done_in)
            blocked_reg <= 1'b0;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    ready_read_a: assert property (rd_res |=> ready_n_out)
        else $error("ready not raised by result read");
    block_result_a: assert property (blocked_reg && conv_valid_in |=> ready_n_out)
        else $error("result accepted during read access");
    accept_result_a: assert property (conv_valid_in && !blocked_reg && !rd_res |=> !ready_n_out)
        else $error("result not accepted");
    result_len_a: assert property (rd_res |=> reg_rlen_out inside {6'h10, 6'h18, 6'h20})
        else $error("bad result length");
    checksum_len_a: assert property (reg_rd_in && reg_addr_in == ars_pkg::ADDR_CHECKSUM |=> reg_rlen_out == 6'h18)
        else $error("bad checksum length");
    rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without read");
    mux_pins_a: assert property (!aux_pin_zero_oe_n_out |-> {aux_pin_one_out, aux_pin_zero_out} == channel_out)
        else $error("aux pins differ from channel");
    pins_pair_a: assert property (aux_pin_zero_oe_n_out == aux_pin_one_oe_n_out)
        else $error("aux pin enables differ");
    reset_run_a: assert property (filter_reset_out |-> !conv_run_out)
        else $error("converting while filter in reset");
    cover property (rd_res ##1 ready_n_out);
    cover property (blocked_reg && conv_valid_in);
    cover property ($fell(aux_pin_zero_oe_n_out));
endmodule : ars_props

bind ars_regs ars_props i_props (.*);

// file: tb/ars_host_model.sv
`timescale 1ns/1ps
// ==========
// far side: filter result source and host sync pin
module ars_host_model (
    input  wire logic        clock_in,
    input  wire logic        fire_in,
    input  wire logic [23:0] value_in,
    input  wire logic        sync_level_in,
    output logic             conv_valid_out = 1'b0,
    output logic      [23:0] conv_sample_out = 24'h000000,
    output logic             sync_out
);
    // sample inverts outside the pulse so a stale value is never mistaken for data
    always_ff @(posedge clock_in)
    begin
        conv_valid_out <= fire_in;
        conv_sample_out <= fire_in ? value_in : ~conv_sample_out;
    end
    // host lowers sync only to hold, or to pace a multi-channel scan
    assign sync_out = sync_level_in;
endmodule : ars_host_model

// file: tb/ars_regs_tb.sv
`timescale 1ns/1ps
module ars_regs_tb;
    logic        clock_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [5:0]  addr = 6'h00;
    logic        wr = 1'b0, rd = 1'b0, done = 1'b0, fire = 1'b0, sync_req = 1'b1;
    logic [23:0] wdata = 24'h000000, value = 24'h000000, xor_in = 24'h000000;
    logic [3:0]  chans = 4'h1, pol = 4'h0;
    logic [31:0] rdata;
    logic [5:0]  rlen;
    logic [23:0] sample;
    logic [1:0]  channel;
    logic        ready_n, f_rst, run, aux0, aux0_oe_n, aux1, aux1_oe_n, conv_valid, sync;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          k;
    always #12.5 clock_in = ~clock_in;
    ars_regs i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_done_in(done), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rlen_out(rlen), .conv_valid_in(conv_valid), .conv_sample_in(sample),
        .chan_enable_in(chans), .polarity_select_in(pol), .other_regs_xor_in(xor_in),
        .sync_in(sync), .ready_n_out(ready_n), .filter_reset_out(f_rst), .conv_run_out(run),
        .channel_out(channel), .aux_pin_zero_out(aux0), .aux_pin_zero_oe_n_out(aux0_oe_n),
        .aux_pin_one_out(aux1), .aux_pin_one_oe_n_out(aux1_oe_n));
    ars_host_model i_host (.clock_in(clock_in), .fire_in(fire), .value_in(value),
        .sync_level_in(sync_req), .conv_valid_out(conv_valid), .conv_sample_out(sample), .sync_out(sync));
    // ==========
    // access tasks
    task step;
        @(posedge clock_in);
        #1;
    endtask : step
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wr_reg(input logic [5:0] a, input logic [23:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step;
        wr = 1'b0;
    endtask : wr_reg
    // done follows at once, so no result is lost to blocking
    task rd_reg(input logic [5:0] a);
        addr = a;
        rd = 1'b1;
        step;
        rd = 1'b0;
        done = 1'b1;
        step;
        done = 1'b0;
    endtask : rd_reg
    task fire_conv(input logic [23:0] v);
        value = v;
        fire = 1'b1;
        step;
        fire = 1'b0;
        step;
        step;
    endtask : fire_conv
    task wait_run;
        for (k = 0; k < 100 && !run; k++)
            step;
        check("run", run, 1'b1);
    endtask : wait_run
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            test_done;
        end
    end
    // ==========
    // tests
    initial
    begin
        repeat (20) @(posedge clock_in);
        #1 rstn_in = 1'b1;
        step;
        rd_reg(ars_pkg::ADDR_AUXCFG);
        check("auxcfg", rdata[31:16], ars_pkg::AUXCFG_RESET);
        rd_reg(ars_pkg::ADDR_CHECKSUM);
        check("sum off", rdata[31:8], 24'h000000);
        rd_reg(6'h3F);
        check("unmapped", rdata, 32'h00000000);
        $display("test reset done");
        xor_in = 24'h123456;
        wr_reg(ars_pkg::ADDR_MODE, 24'h000300);
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h000020);
        step;
        rd_reg(ars_pkg::ADDR_CHECKSUM);
        check("sum", rdata[31:8], 24'h123F56);
        rd_reg(ars_pkg::ADDR_STATUS);
        check("err clean", rdata[28], 1'b0);
        wr_reg(ars_pkg::ADDR_MODE, 24'h000100);
        step;
        rd_reg(ars_pkg::ADDR_CHECKSUM);
        check("sum new", rdata[31:8], 24'h123D56);
        rd_reg(ars_pkg::ADDR_STATUS);
        check("err set", rdata[28], 1'b1);
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h000000);
        step; // flag clears one clock after the enable drops
        rd_reg(ars_pkg::ADDR_STATUS);
        check("err clear", rdata[28], 1'b0);
        rd_reg(ars_pkg::ADDR_CHECKSUM);
        check("sum zero", rdata[31:8], 24'h000000);
        $display("test checksum done");
        wait_run;
        fire_conv(24'h000010);
        check("ready low", ready_n, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            rd_reg(ars_pkg::ADDR_RESULT);
            check("bipolar", rdata[31:8], 24'h800010);
            check("len24", rlen, ars_pkg::LEN_24);
            check("ready high", ready_n, 1'b1);
        end
        pol = 4'h1;
        fire_conv(24'h000010);
        pol = 4'h0;
        rd_reg(ars_pkg::ADDR_RESULT);
        check("unipolar", rdata[31:8], 24'h000020);
        addr = ars_pkg::ADDR_RESULT;
        rd = 1'b1;
        step;
        rd = 1'b0;
        fire_conv(24'h000777);
        check("blocked ready", ready_n, 1'b1);
        done = 1'b1;
        step;
        done = 1'b0;
        rd_reg(ars_pkg::ADDR_RESULT);
        check("blocked data", rdata[31:8], 24'h000020);
        $display("test result done");
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h000001);
        rd_reg(ars_pkg::ADDR_RESULT);
        check("old short", rdata[31:16], 16'h0000);
        fire_conv(24'h123400);
        rd_reg(ars_pkg::ADDR_RESULT);
        check("short", rdata[31:16], 16'h9234);
        check("len16", rlen, ars_pkg::LEN_16);
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h000041);
        rd_reg(ars_pkg::ADDR_RESULT);
        check("len16 st", rlen, ars_pkg::LEN_24);
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h000040);
        rd_reg(ars_pkg::ADDR_RESULT);
        check("len32", rlen, ars_pkg::LEN_32);
        check("status", rdata[6:0], 7'h00);
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h000000);
        $display("test length done");
        chans = 4'h3;
        wr_reg(ars_pkg::ADDR_AUXCFG, 24'h001800);
        step;
        check("oe", aux0_oe_n, 1'b0);
        wait_run;
        fire_conv(24'h000001);
        for (k = 0; k < 200 && !run; k++)
            step;
        check("settle", (k >= 40 && k <= 42), 1'b1);
        check("chan", channel, 2'h1);
        check("pins", {aux1, aux0}, 2'h1);
        fire_conv(24'h000002);
        check("wrap", channel, 2'h0);
        $display("test mux done");
        sync_req = 1'b0;
        step;
        step;
        check("sync rst", {f_rst, run}, 2'b10);
        sync_req = 1'b1;
        wait_run;
        wr_reg(ars_pkg::ADDR_IFMODE, 24'h001000);
        wait_run;
        sync_req = 1'b0;
        step;
        step;
        check("alt no rst", f_rst, 1'b0);
        fire_conv(24'h000003);
        repeat (60) step;
        check("alt hold", run, 1'b0);
        sync_req = 1'b1;
        wait_run;
        $display("test sync done");
        test_done;
    end
endmodule : ars_regs_tb
